// >>> inc/mpm_dec_if.sv
`timescale 1ns/1ps
interface mpm_dec_if;
  logic [15:0] reg_addr;
  logic [15:0] map_param;
  logic map_half;
  mpm_pkg::mpm_region_t region;
  logic [15:0] param_num;
  logic half;
  modport dec (
    input reg_addr,
    input map_param,
    input map_half,
    output region,
    output param_num,
    output half
  );
  modport user (
    output reg_addr,
    output map_param,
    output map_half,
    input region,
    input param_num,
    input half
  );
endinterface : mpm_dec_if

// >>> inc/mpm_pkg.sv
package mpm_pkg;
  // ----------------------------------------
  // Connection handling
  // ----------------------------------------
  localparam logic [1:0] MAX_SESSIONS = 2'h3;
  localparam logic [15:0] SERVER_PORT = 16'h01f6;
  // ----------------------------------------
  // Register space layout
  // ----------------------------------------
  localparam logic [15:0] USER_FIRST = 16'h0001;
  localparam logic [15:0] USER_LAST = 16'h0100;
  localparam logic [15:0] FIXED_BASE = 16'h0211;
  localparam logic [15:0] PARAM_FIRST = 16'h0001;
  // ----------------------------------------
  // Request spaces
  // ----------------------------------------
  localparam logic [1:0] SPACE_HOLDING = 2'h0;
  localparam logic [1:0] SPACE_INPUT = 2'h1;
  localparam logic [1:0] SPACE_COIL = 2'h2;
  localparam logic [1:0] SPACE_DISCRETE = 2'h3;
  // ----------------------------------------
  // Parameter data types
  // ----------------------------------------
  localparam logic [2:0] TYPE_NONE = 3'h0;
  localparam logic [2:0] TYPE_BYTE = 3'h1;
  localparam logic [2:0] TYPE_WORD = 3'h2;
  localparam logic [2:0] TYPE_DWORD = 3'h3;
  localparam logic [2:0] TYPE_STRING = 3'h4;
  // ----------------------------------------
  // Exception answers
  // ----------------------------------------
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ADDRESS = 8'h02;
  // ----------------------------------------
  // Address region kinds and access states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MPM_REG_USER = 2'h0,
    MPM_REG_RESERVED = 2'h1,
    MPM_REG_FIXED = 2'h2
  } mpm_region_t;
  typedef enum logic [3:0] {
    MPM_IDLE = 4'h1,
    MPM_DEC = 4'h2,
    MPM_DATA = 4'h4,
    MPM_RESP = 4'h8
  } mpm_state_t;
endpackage : mpm_pkg

// >>> rtl/mpm_addr_decode.sv
`timescale 1ns/1ps
module mpm_addr_decode (
  mpm_dec_if.dec d
);
  // ----------------------------------------
  // Region selection
  // ----------------------------------------
  wire [15:0] fixed_off = d.reg_addr - mpm_pkg::FIXED_BASE;
  wire is_user = (d.reg_addr >= mpm_pkg::USER_FIRST) &&
                 (d.reg_addr <= mpm_pkg::USER_LAST);
  wire is_fixed = d.reg_addr >= mpm_pkg::FIXED_BASE;
  // Fixed area: two registers per parameter
  wire [15:0] fixed_num = {1'b0, fixed_off[15:1]} + mpm_pkg::PARAM_FIRST;
  // User area goes through the external table
  assign d.region = is_user ? mpm_pkg::MPM_REG_USER :
                    is_fixed ? mpm_pkg::MPM_REG_FIXED :
                    mpm_pkg::MPM_REG_RESERVED;
  assign d.param_num = is_user ? d.map_param : fixed_num;
  assign d.half = is_user ? d.map_half : fixed_off[0];
endmodule : mpm_addr_decode

// >>> rtl/mpm_param_mapper.sv
`timescale 1ns/1ps
module mpm_param_mapper (
  input wire logic clk,
  input wire logic reset,
  input wire logic conn_req,
  input wire logic [15:0] conn_port,
  input wire logic conn_close,
  input wire logic [7:0] max_conn,
  output logic conn_accept,
  output logic conn_refuse,
  output logic [1:0] open_count,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_first,
  input wire logic req_write,
  input wire logic [1:0] req_space,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [7:0] rsp_exc,
  output logic [7:0] map_index,
  input wire logic [15:0] map_param,
  input wire logic map_half,
  input wire logic high_word_first,
  output logic param_rd,
  output logic param_wr,
  output logic [15:0] param_num,
  output logic [31:0] param_wdata,
  input wire logic [31:0] param_rdata,
  input wire logic [2:0] param_type,
  input wire logic param_exists
);
  // ----------------------------------------
  // Connection admission
  // ----------------------------------------
  logic [1:0] open_ff;
  logic accept_ff;
  logic refuse_ff;
  wire limit_zero = max_conn == 8'h00;
  wire below_max = (open_ff < mpm_pkg::MAX_SESSIONS) &&
                   ({6'h00, open_ff} < max_conn);
  wire port_ok = conn_port == mpm_pkg::SERVER_PORT;
  wire admit = conn_req && port_ok && !limit_zero && below_max;
  wire drop = conn_close && (open_ff != 2'h0);
  wire [1:0] nxt_open = open_ff + {1'b0, admit} - {1'b0, drop};
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      open_ff <= 2'h0;
      accept_ff <= 1'b0;
      refuse_ff <= 1'b0;
    end
    else
    begin
      open_ff <= nxt_open;
      accept_ff <= admit;
      refuse_ff <= conn_req && !admit;
    end
  end
  assign open_count = open_ff;
  assign conn_accept = accept_ff;
  assign conn_refuse = refuse_ff;
  // ----------------------------------------
  // Request capture and sequencing
  // ----------------------------------------
  mpm_pkg::mpm_state_t state_ff;
  mpm_pkg::mpm_state_t nxt_state;
  logic ready_ff;
  logic write_ff;
  logic [1:0] space_ff;
  logic [15:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [7:0] index_ff;
  logic half_ff;
  logic take;
  assign take = req_valid && ready_ff && (state_ff == mpm_pkg::MPM_IDLE);
  always_comb
  begin
    case (state_ff)
      mpm_pkg::MPM_IDLE: nxt_state = take ? mpm_pkg::MPM_DEC : state_ff;
      mpm_pkg::MPM_DEC: nxt_state = mpm_pkg::MPM_DATA;
      mpm_pkg::MPM_DATA: nxt_state = mpm_pkg::MPM_RESP;
      mpm_pkg::MPM_RESP: nxt_state = mpm_pkg::MPM_IDLE;
      default: nxt_state = mpm_pkg::MPM_IDLE;
    endcase
  end
  // User table is looked up with the zero-based register index
  wire [15:0] user_index = req_addr - mpm_pkg::USER_FIRST;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= mpm_pkg::MPM_IDLE;
      ready_ff <= 1'b0;
      write_ff <= 1'b0;
      space_ff <= mpm_pkg::SPACE_HOLDING;
      addr_ff <= 16'h0000;
      wdata_ff <= 16'h0000;
      index_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      ready_ff <= nxt_state == mpm_pkg::MPM_IDLE;
      if (take)
      begin
        write_ff <= req_write;
        space_ff <= req_space;
        addr_ff <= req_addr;
        wdata_ff <= req_wdata;
        index_ff <= user_index[7:0];
      end
    end
  end
  assign req_ready = ready_ff;
  assign map_index = index_ff;
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  mpm_dec_if dif ();
  assign dif.reg_addr = addr_ff;
  assign dif.map_param = map_param;
  assign dif.map_half = map_half;
  mpm_addr_decode u_dec (
    .d(dif.dec)
  );
  // Empty user slot reads as unused
  wire user_empty = (dif.region == mpm_pkg::MPM_REG_USER) &&
                    (map_param == 16'h0000);
  wire in_dec = state_ff == mpm_pkg::MPM_DEC;
  wire in_data = state_ff == mpm_pkg::MPM_DATA;
  logic [15:0] num_ff;
  logic rd_ff;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      num_ff <= 16'h0000;
      half_ff <= 1'b0;
      rd_ff <= 1'b0;
    end
    else
    begin
      rd_ff <= in_dec && !user_empty &&
               (dif.region != mpm_pkg::MPM_REG_RESERVED);
      if (in_dec)
      begin
        num_ff <= dif.param_num;
        half_ff <= dif.half;
      end
    end
  end
  assign param_rd = rd_ff;
  assign param_num = num_ff;
  // ----------------------------------------
  // Data placement
  // ----------------------------------------
  // Only holding and input spaces exist, both with one map
  wire bad_space = (space_ff == mpm_pkg::SPACE_COIL) ||
                   (space_ff == mpm_pkg::SPACE_DISCRETE);
  wire no_target = !rd_ff;
  wire bad_param = rd_ff && !param_exists;
  wire is_byte = param_type == mpm_pkg::TYPE_BYTE;
  wire is_word = param_type == mpm_pkg::TYPE_WORD;
  // Whole-array numbers arrive as dwords: first four bytes only
  wire is_dword = param_type == mpm_pkg::TYPE_DWORD;
  wire is_str = param_type == mpm_pkg::TYPE_STRING;
  wire [15:0] word_lo = param_rdata[15:0];
  wire [15:0] word_hi = param_rdata[31:16];
  wire [15:0] dword_word = (half_ff ^ high_word_first) ? word_hi :
                           word_lo;
  // Char 0 in bits 7:0, so it lands in the low byte
  wire [15:0] str_word = half_ff ? word_hi : word_lo;
  wire [15:0] small_word = half_ff ? 16'h0000 :
                           is_byte ? {8'h00, param_rdata[7:0]} :
                           word_lo;
  wire [15:0] rd_word = (no_target || bad_param) ? 16'h0000 :
                        is_dword ? dword_word :
                        is_str ? str_word :
                        (is_byte || is_word) ? small_word :
                        16'h0000;
  wire [7:0] exc = bad_space ? mpm_pkg::EXC_FUNCTION :
                   bad_param ? mpm_pkg::EXC_ADDRESS :
                   mpm_pkg::EXC_NONE;
  // ----------------------------------------
  // Writes and half pairing
  // ----------------------------------------
  // Pending first half is kept across requests until the next wide write (a second half clears it) or a request taken with req_first
  logic pend_ff;
  logic [15:0] pend_num_ff;
  logic [15:0] pend_word_ff;
  wire wr_ok = in_data && write_ff && !bad_space && !bad_param &&
               !no_target;
  wire wide = is_dword || is_str;
  wire small_wr = wr_ok && (is_byte || is_word) && !half_ff;
  wire pair_ok = wr_ok && wide && half_ff && pend_ff &&
                 (pend_num_ff == num_ff);
  wire [31:0] pair_data = (high_word_first && !is_str) ?
                          {pend_word_ff, wdata_ff} :
                          {wdata_ff, pend_word_ff};
  wire [31:0] small_data = is_byte ? {24'h000000, wdata_ff[7:0]} :
                           {16'h0000, wdata_ff};
  always_ff @(posedge clk)
  begin
    if (reset || (take && req_first))
    begin
      pend_ff <= 1'b0;
      pend_num_ff <= 16'h0000;
      pend_word_ff <= 16'h0000;
    end
    else if (wr_ok && wide)
    begin
      pend_ff <= !half_ff;
      pend_num_ff <= num_ff;
      pend_word_ff <= wdata_ff;
    end
  end
  logic wr_ff;
  logic [31:0] wdata_out_ff;
  logic rsp_valid_ff;
  logic [15:0] rsp_data_ff;
  logic [7:0] rsp_exc_ff;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ff <= 1'b0;
      wdata_out_ff <= 32'h00000000;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 16'h0000;
      rsp_exc_ff <= 8'h00;
    end
    else
    begin
      wr_ff <= small_wr || pair_ok;
      rsp_valid_ff <= in_data;
      if (small_wr || pair_ok)
        wdata_out_ff <= pair_ok ? pair_data : small_data;
      if (in_data)
      begin
        rsp_data_ff <= write_ff ? 16'h0000 : rd_word;
        rsp_exc_ff <= exc;
      end
    end
  end
  assign param_wr = wr_ff;
  assign param_wdata = wdata_out_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign rsp_exc = rsp_exc_ff;
endmodule : mpm_param_mapper

// >>> verification/mpm_asserts.sv
`timescale 1ns/1ps
module mpm_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic conn_req,
  input wire logic [15:0] conn_port,
  input wire logic conn_close,
  input wire logic [7:0] max_conn,
  input wire logic conn_refuse,
  input wire logic [1:0] open_count,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [1:0] req_space,
  input wire logic [15:0] req_addr,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_exc,
  input wire logic param_rd,
  input wire logic param_wr,
  input wire logic [15:0] param_num
);
  // ------
  // Port checks
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [15:0] pn_ff;
  wire take = req_valid && req_ready;
  wire fix = req_addr >= 16'h0211 && !req_space[1];
  wire resv = req_addr > 16'h0100 && req_addr < 16'h0211;
  // Held from take: the address may move on meanwhile
  always_ff @(posedge clk)
    if (take)
      pn_ff <= ((req_addr - 16'h0211) >> 1) + 16'h0001;
  a_port_refuse: assert property (conn_req && conn_port != 16'h01f6
    |=> conn_refuse) else $error("foreign port admitted");
  a_zero_limit: assert property (conn_req && max_conn == 8'h00
    |=> conn_refuse) else $error("admitted with zero limit");
  a_full_refuse: assert property (conn_req && !conn_close
    && open_count == 2'h3 |=> conn_refuse) else $error("fourth admitted");
  a_coil_exc: assert property (take && req_space[1] |-> ##[2:4]
    rsp_valid && rsp_exc == 8'h01) else $error("coil space served");
  a_fixed_num: assert property (take && fix |-> ##[1:3] param_rd
    && param_num == pn_ff) else $error("fixed area number wrong");
  a_resv_nowr: assert property (take && resv
    |=> !param_wr [*4]) else $error("reserved write reached store");
  a_wr_rsp: assert property (param_wr |-> rsp_valid)
    else $error("store write outside answer");
  a_ready_gap: assert property (take |=> !req_ready [*3])
    else $error("ready during access");
  c_coil: cover property (take && req_space[1]);
  c_write: cover property (param_wr);
  c_full: cover property (conn_req && open_count == 2'h3);
endmodule : mpm_asserts
bind mpm_param_mapper mpm_asserts u_asserts (.*);

// >>> verification/mpm_param_mapper_tb.sv
`timescale 1ns/1ps
module mpm_param_mapper_tb;
  // ------
  // Bench
  // ------
  logic clk = 1'h0, reset = 1'h1, conn_req = 1'h0, conn_close = 1'h0;
  logic req_valid = 1'h0, req_first = 1'h0, req_write = 1'h0;
  logic high_word_first = 1'h0;
  logic [15:0] conn_port = 16'h0, req_addr = 16'h0, req_wdata = 16'h0;
  logic [7:0] max_conn = 8'h0;
  logic [1:0] req_space = 2'h0;
  logic conn_accept, conn_refuse, req_ready, rsp_valid, map_half;
  logic param_rd, param_wr, param_exists;
  logic [1:0] open_count;
  logic [15:0] rsp_data, map_param, param_num, gd, d0, d1;
  logic [7:0] rsp_exc, map_index, ge;
  logic [31:0] param_wdata, param_rdata;
  logic [2:0] param_type;
  logic [31:0] sh [1:5] = '{32'hf5, 32'ha55a, 32'h12345678,
    32'h33323130, 32'h37363534};
  logic [15:0] adr [16] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h101,
    16'h210, 16'h211, 16'h212, 16'h213, 16'h215, 16'h216, 16'h217,
    16'h218, 16'h21a, 16'h21b};
  // Port, limit, admitted
  logic [24:0] cp [6] = '{25'h3ec00, 25'h3ee06, 25'h3edff, 25'h3edff,
    25'h3edff, 25'h3edfe};
  int miscompares = 0, checks_done = 0, cyc = 0;
  always #5 clk = ~clk;
  mpm_param_mapper DUT (.*);
  mpm_store_model u_store (.*);
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [1:0] s,
    input logic [15:0] a, input logic [15:0] d, input logic f);
    int n;
    @(posedge clk);
    {req_valid, req_write, req_space, req_first} <= {1'h1, w, s, f};
    {req_addr, req_wdata} <= {a, d};
    @(posedge clk);
    for (n = 0; !req_ready && n < 20; n++)
      @(posedge clk);
    req_valid <= 1'h0;
    for (n = 0; !rsp_valid && n < 9; n++)
      @(posedge clk);
    // A missing answer is a failure, not stale data
    if (rsp_valid !== 1'h1)
      summarize(1);
    {ge, gd} = {rsp_exc, rsp_data};
  endtask : acc
  function automatic logic [23:0] exp_rd(input logic [1:0] s,
    input logic [15:0] a);
    logic [15:0] p;
    logic h;
    logic [31:0] v;
    p = a == 16'h1 ? 16'h2 : (a == 16'h2 || a == 16'h3) ? 16'h3 : 16'h0;
    h = a == 16'h3;
    if (a >= 16'h211)
    begin
      p = ((a - 16'h211) >> 1) + 16'h1;
      h = ~a[0];
    end
    if (s[1] || p > 16'h5)
      return s[1] ? 24'h10000 : 24'h20000;
    v = p == 16'h0 ? 32'h0 : sh[p[2:0]];
    if (p == 16'h1)
      v = {24'h0, v[7:0]};
    if (p == 16'h3 && high_word_first)
      v = {v[15:0], v[31:16]};
    return {8'h0, (h && p < 16'h3) ? 16'h0 : h ? v[31:16] : v[15:0]};
  endfunction : exp_rd
  task automatic rd(input logic [1:0] s, input logic [15:0] a);
    logic [23:0] e;
    acc(1'h0, s, a, 16'h0, 1'h1);
    e = exp_rd(s, a);
    chk(e[23:16] != 8'h0 ? {ge, 16'h0} : {ge, gd}, e);
  endtask : rd
  task automatic wp(input logic [15:0] a, input logic [2:0] p);
    acc(1'h1, 2'h0, a, d0, 1'h1);
    acc(1'h1, 2'h0, a + 16'h1, d1, 1'h0);
    sh[p] = high_word_first && p == 3'h3 ? {d0, d1} : {d1, d0};
  endtask : wp
  task automatic summarize(input int t);
    miscompares += t;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
      summarize(1);
  end
  initial
  begin
    void'($urandom(32'hde7b));
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    repeat (2) @(posedge clk);
    foreach (cp[i])
    begin
      {conn_req, conn_port, max_conn} <= {1'h1, cp[i][24:1]};
      @(posedge clk);
      conn_req <= 1'h0;
      @(posedge clk);
      chk({22'h0, conn_accept, conn_refuse}, {22'h0, cp[i][0], !cp[i][0]});
    end
    chk({22'h0, open_count}, 24'h3);
    conn_close <= 1'h1;
    @(posedge clk);
    conn_close <= 1'h0;
    @(posedge clk);
    chk({22'h0, open_count}, 24'h2);
    {conn_req, conn_close} <= 2'h3;
    @(posedge clk);
    {conn_req, conn_close} <= 2'h0;
    @(posedge clk);
    chk({21'h0, open_count, conn_accept}, 24'h5);
    {conn_req, max_conn} <= {1'h1, 8'h02};
    @(posedge clk);
    conn_req <= 1'h0;
    @(posedge clk);
    chk({22'h0, conn_accept, conn_refuse}, 24'h1);
    for (int s = 0; s < 8; s++)
    begin
      high_word_first <= s[0];
      foreach (adr[i])
        rd(s[2:1], adr[i]);
    end
    {d0, d1} = 32'h9c814e27;
    acc(1'h1, 2'h0, 16'h216, d1, 1'h1);
    acc(1'h1, 2'h0, 16'h215, d0, 1'h1);
    acc(1'h1, 2'h0, 16'h214, d0, 1'h1);
    chk({ge, gd}, 24'h0);
    acc(1'h1, 2'h0, 16'h211, d0, 1'h1);
    acc(1'h1, 2'h0, 16'h213, d1, 1'h1);
    sh[1] = {16'h0, d0};
    sh[2] = {16'h0, d1};
    wp(16'h219, 3'h5);
    foreach (adr[i])
      rd(2'h0, adr[i]);
    repeat (30)
    begin
      high_word_first <= 1'($urandom);
      {d0, d1} = $urandom;
      wp($urandom % 2 ? 16'h2 : 16'h215, 3'h3);
      rd(2'($urandom), adr[$urandom % 16]);
    end
    summarize(0);
  end
endmodule : mpm_param_mapper_tb

// >>> verification/mpm_store_model.sv
`timescale 1ns/1ps
module mpm_store_model (
  input wire logic clk,
  input wire logic [7:0] map_index,
  output logic [15:0] map_param,
  output logic map_half,
  input wire logic param_wr,
  input wire logic [15:0] param_num,
  input wire logic [31:0] param_wdata,
  output logic [31:0] param_rdata,
  output logic [2:0] param_type,
  output logic param_exists
);
  // ------
  // Store and user table
  // ------
  logic [31:0] mem [1:5] = '{32'hf5, 32'ha55a, 32'h12345678,
    32'h33323130, 32'h37363534};
  wire hit = param_num != 16'h0 && param_num <= 16'h5;
  wire [2:0] pi = param_num[2:0];
  // Slot 0 word, slots 1-2 dword halves, rest empty
  assign map_param = map_index == 8'h0 ? 16'h2 :
    map_index <= 8'h2 ? 16'h3 : 16'h0;
  assign map_half = map_index == 8'h2;
  assign param_exists = hit;
  // Misses show a pattern, never stale data
  assign param_rdata = hit ? mem[pi] : 32'ha5c35a3c;
  assign param_type = !hit ? 3'h0 : pi < 3'h4 ? pi : 3'h4;
  always @(posedge clk)
    if (param_wr && hit)
      mem[pi] <= param_wdata;
endmodule : mpm_store_model
